// *** logic/tcrc_pkg.sv ***
// shared constants and types for the transceiver channel reset control block
package tcrc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int NUM_CHANNELS = 4;
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 32;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets (byte addresses, one aligned word each)
    localparam logic [7:0] SW_TX_RESET_OFFSET = 8'h00;
    localparam logic [7:0] SW_RX_RESET_OFFSET = 8'h04;
    localparam logic [7:0] SW_ANALOG_RESET_OFFSET = 8'h08;
    localparam logic [7:0] SW_POWERDOWN_OFFSET = 8'h0c;
    localparam logic [7:0] LIVE_STATUS_OFFSET = 8'h10;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h14;
    localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h18;
    localparam logic [7:0] IRQ_CLEAR_OFFSET = 8'h1c;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [3:0] SW_RESET_RESET_VALUE = 4'h0;
    localparam logic SW_POWERDOWN_RESET_VALUE = 1'b0;
    localparam logic [16:0] IRQ_RESET_VALUE = 17'h00000;

    ////////////////////////////////////////////////////////////////////////////
    // live status field positions
    localparam int STAT_PLL_LOCKED_POS = 0;
    localparam int STAT_POWERDOWN_POS = 1;
    localparam int STAT_FREQ_LOCKED_POS = 4;
    localparam int STAT_TX_HELD_POS = 8;
    localparam int STAT_RX_HELD_POS = 12;
    localparam int STAT_CDR_HELD_POS = 16;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt field positions (status, enable and clear share them)
    localparam int IRQ_TX_SHORT_POS = 0;
    localparam int IRQ_RX_SHORT_POS = 4;
    localparam int IRQ_ANALOG_SHORT_POS = 8;
    localparam int IRQ_FREQ_LOST_POS = 12;
    localparam int IRQ_PLL_LOST_POS = 16;
    localparam int IRQ_WIDTH = 17;

    ////////////////////////////////////////////////////////////////////////////
    // timing: least reset pulse, in parallel clock cycles
    localparam int MIN_PULSE_CYCLES = 2;
    localparam int PULSE_COUNT_WIDTH = 2;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef struct packed {
        logic tx_digital;
        logic rx_digital;
        logic rx_analog;
    } tcrc_chan_reset_type;

    typedef enum logic [2:0] {
        PULSE_IDLE = 3'b001,
        PULSE_COUNT = 3'b010,
        PULSE_HELD = 3'b100
    } tcrc_pulse_state_type;

endpackage

// *** logic/tcrc_pulse_check.sv ***
// watches one reset input and flags pulses shorter than the least width
`timescale 1ns/1ps
`default_nettype none
module tcrc_pulse_check (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic level_in,
    output logic short_out
);

    tcrc_pkg::tcrc_pulse_state_type state;
    tcrc_pkg::tcrc_pulse_state_type next_state;
    logic [tcrc_pkg::PULSE_COUNT_WIDTH-1:0] count;
    logic [tcrc_pkg::PULSE_COUNT_WIDTH-1:0] next_count;
    localparam logic [tcrc_pkg::PULSE_COUNT_WIDTH-1:0] COUNT_LAST =
        tcrc_pkg::PULSE_COUNT_WIDTH'(tcrc_pkg::MIN_PULSE_CYCLES - 1);

    always_comb begin
        next_count = count + 2'h1;
        next_state = state;
        unique case (state)
            tcrc_pkg::PULSE_IDLE: begin
                if (level_in) begin
                    next_state = tcrc_pkg::PULSE_COUNT;
                end
            end
            tcrc_pkg::PULSE_COUNT: begin
                if (!level_in) begin
                    next_state = tcrc_pkg::PULSE_IDLE;
                end else if (count >= COUNT_LAST) begin
                    next_state = tcrc_pkg::PULSE_HELD;
                end
            end
            tcrc_pkg::PULSE_HELD: begin
                if (!level_in) begin
                    next_state = tcrc_pkg::PULSE_IDLE;
                end
            end
            default: begin
                next_state = tcrc_pkg::PULSE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            state <= tcrc_pkg::PULSE_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in || state != tcrc_pkg::PULSE_COUNT) begin
            count <= 2'h1;
        end else begin
            count <= next_count;
        end
    end

    // a pulse that drops while still counting is too short
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            short_out <= 1'b0;
        end else begin
            short_out <= (state == tcrc_pkg::PULSE_COUNT) && !level_in;
        end
    end

endmodule
`default_nettype wire

// *** logic/tcrc_lock_track.sv ***
// turns a lock level into a one-cycle pulse when the lock is lost
`timescale 1ns/1ps
`default_nettype none
module tcrc_lock_track (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic lock_in,
    output logic lost_out
);

    logic lock_prev;

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            lock_prev <= 1'b0;
        end else begin
            lock_prev <= lock_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            lost_out <= 1'b0;
        end else begin
            lost_out <= lock_prev && !lock_in;
        end
    end

endmodule
`default_nettype wire

// *** logic/tcrc_top.sv ***
// per-channel reset and block power-down control for a transceiver block
//
// How it works
// - each channel has its own transmit, receive and analog reset inputs acting on that channel only.
// - one block power-down input acts on both PLL kinds and on every channel of the block.
// - every reset and the power-down reach their targets through gates, with no clock edge.
// - the transmit digital reset holds the whole transmit coding sublayer in reset.
// - the receive digital reset holds the whole receive coding sublayer and its verifiers in reset.
// - the receive analog reset holds the channel's clock-data-recovery unit in reset.
// - block power-down powers down coding sublayer and medium attachment of all channels.
// - PLL lock status is high while a PLL is locked to the reference clock.
// - receive frequency lock is high in lock-to-data mode and low in lock-to-reference mode.
`timescale 1ns/1ps
`default_nettype none
module tcrc_top (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire tcrc_pkg::tcrc_chan_reset_type [tcrc_pkg::NUM_CHANNELS-1:0] chan_reset_in,
    input wire logic block_powerdown_in,
    input wire logic pll_lock_detect_in,
    input wire logic [tcrc_pkg::NUM_CHANNELS-1:0] cdr_lock_to_data_in,
    input wire logic [tcrc_pkg::ADDR_WIDTH-1:0] reg_addr_in,
    input wire logic [tcrc_pkg::DATA_WIDTH-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [tcrc_pkg::DATA_WIDTH-1:0] reg_rdata_out,
    output logic [tcrc_pkg::NUM_CHANNELS-1:0] tx_pcs_reset_out,
    output logic [tcrc_pkg::NUM_CHANNELS-1:0] rx_pcs_reset_out,
    output logic [tcrc_pkg::NUM_CHANNELS-1:0] cdr_reset_out,
    output logic [tcrc_pkg::NUM_CHANNELS-1:0] pcs_powerdown_out,
    output logic [tcrc_pkg::NUM_CHANNELS-1:0] pma_powerdown_out,
    output logic mpll_powerdown_out,
    output logic gpll_powerdown_out,
    output logic pll_locked_out,
    output logic [tcrc_pkg::NUM_CHANNELS-1:0] rx_freq_locked_out,
    output logic irq_out
);

    localparam int NCH = tcrc_pkg::NUM_CHANNELS;

    ////////////////////////////////////////////////////////////////////////////
    // software-held state

    logic [NCH-1:0] sw_tx_reset;
    logic [NCH-1:0] sw_rx_reset;
    logic [NCH-1:0] sw_analog_reset;
    logic sw_powerdown;
    logic [tcrc_pkg::IRQ_WIDTH-1:0] irq_status;
    logic [tcrc_pkg::IRQ_WIDTH-1:0] irq_enable;
    logic [tcrc_pkg::IRQ_WIDTH-1:0] irq_events;
    logic [tcrc_pkg::IRQ_WIDTH-1:0] irq_clear;
    logic [tcrc_pkg::DATA_WIDTH-1:0] live_status;
    logic [tcrc_pkg::DATA_WIDTH-1:0] next_rdata;

    // per-channel event pulses, plus the single PLL-loss pulse
    logic [NCH-1:0] tx_short;
    logic [NCH-1:0] rx_short;
    logic [NCH-1:0] analog_short;
    logic [NCH-1:0] freq_lost;
    logic pll_lost;

    // merged controls
    logic powerdown;
    logic [NCH-1:0] tx_reset_raw;
    logic [NCH-1:0] rx_reset_raw;
    logic [NCH-1:0] analog_reset_raw;

    logic write_hit_tx;
    logic write_hit_rx;
    logic write_hit_analog;
    logic write_hit_powerdown;
    logic write_hit_enable;
    logic write_hit_clear;

    ////////////////////////////////////////////////////////////////////////////
    // reset and power-down paths
    // these are pure gates: the inputs are asynchronous, so waiting for a
    // clock edge would stretch or delay a reset the fabric already timed

    // the power-down pin and the software bit act alike; neither depends
    // on the channel resets
    assign powerdown = block_powerdown_in | sw_powerdown;

    assign mpll_powerdown_out = powerdown;
    assign gpll_powerdown_out = powerdown;

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_chan
            assign tx_reset_raw[ch] = chan_reset_in[ch].tx_digital;
            assign rx_reset_raw[ch] = chan_reset_in[ch].rx_digital;
            assign analog_reset_raw[ch] = chan_reset_in[ch].rx_analog;

            // each channel sees only its own inputs
            // held exactly while an input is high, released with it
            assign tx_pcs_reset_out[ch] = tx_reset_raw[ch] | sw_tx_reset[ch];
            assign rx_pcs_reset_out[ch] = rx_reset_raw[ch] | sw_rx_reset[ch];
            assign cdr_reset_out[ch] = analog_reset_raw[ch] | sw_analog_reset[ch];

            assign pcs_powerdown_out[ch] = powerdown;
            assign pma_powerdown_out[ch] = powerdown;

            // a recovery unit in reset or powered down falls back to the
            // reference, so it cannot claim lock-to-data then
            assign rx_freq_locked_out[ch] = cdr_lock_to_data_in[ch]
                & ~cdr_reset_out[ch] & ~powerdown;

            // pulse-width watch on the fabric's inputs only; software bits
            // are held for whole register writes and need no check
            tcrc_pulse_check u_tx_width (
                .clock_in(clock_in),
                .nrst_in(nrst_in),
                .level_in(tx_reset_raw[ch]),
                .short_out(tx_short[ch])
            );

            tcrc_pulse_check u_rx_width (
                .clock_in(clock_in),
                .nrst_in(nrst_in),
                .level_in(rx_reset_raw[ch]),
                .short_out(rx_short[ch])
            );

            tcrc_pulse_check u_analog_width (
                .clock_in(clock_in),
                .nrst_in(nrst_in),
                .level_in(analog_reset_raw[ch]),
                .short_out(analog_short[ch])
            );

            tcrc_lock_track u_freq_lock (
                .clock_in(clock_in),
                .nrst_in(nrst_in),
                .lock_in(rx_freq_locked_out[ch]),
                .lost_out(freq_lost[ch])
            );
        end
    endgenerate

    // a powered-down PLL is not locked whatever the detector says
    assign pll_locked_out = pll_lock_detect_in & ~powerdown;

    tcrc_lock_track u_pll_lock (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .lock_in(pll_locked_out),
        .lost_out(pll_lost)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register write decode

    assign write_hit_tx = reg_write_in && reg_addr_in == tcrc_pkg::SW_TX_RESET_OFFSET;
    assign write_hit_rx = reg_write_in && reg_addr_in == tcrc_pkg::SW_RX_RESET_OFFSET;
    assign write_hit_analog = reg_write_in
        && reg_addr_in == tcrc_pkg::SW_ANALOG_RESET_OFFSET;
    assign write_hit_powerdown = reg_write_in
        && reg_addr_in == tcrc_pkg::SW_POWERDOWN_OFFSET;
    assign write_hit_enable = reg_write_in && reg_addr_in == tcrc_pkg::IRQ_ENABLE_OFFSET;
    assign write_hit_clear = reg_write_in && reg_addr_in == tcrc_pkg::IRQ_CLEAR_OFFSET;

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            sw_tx_reset <= tcrc_pkg::SW_RESET_RESET_VALUE;
        end else if (write_hit_tx) begin
            sw_tx_reset <= reg_wdata_in[NCH-1:0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            sw_rx_reset <= tcrc_pkg::SW_RESET_RESET_VALUE;
        end else if (write_hit_rx) begin
            sw_rx_reset <= reg_wdata_in[NCH-1:0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            sw_analog_reset <= tcrc_pkg::SW_RESET_RESET_VALUE;
        end else if (write_hit_analog) begin
            sw_analog_reset <= reg_wdata_in[NCH-1:0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            sw_powerdown <= tcrc_pkg::SW_POWERDOWN_RESET_VALUE;
        end else if (write_hit_powerdown) begin
            sw_powerdown <= reg_wdata_in[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts

    always_comb begin
        irq_events = '0;
        irq_events[tcrc_pkg::IRQ_TX_SHORT_POS +: NCH] = tx_short;
        irq_events[tcrc_pkg::IRQ_RX_SHORT_POS +: NCH] = rx_short;
        irq_events[tcrc_pkg::IRQ_ANALOG_SHORT_POS +: NCH] = analog_short;
        irq_events[tcrc_pkg::IRQ_FREQ_LOST_POS +: NCH] = freq_lost;
        irq_events[tcrc_pkg::IRQ_PLL_LOST_POS] = pll_lost;
    end

    assign irq_clear = write_hit_clear ? reg_wdata_in[tcrc_pkg::IRQ_WIDTH-1:0] : '0;

    // an event in the clearing cycle survives: set wins over clear
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            irq_status <= tcrc_pkg::IRQ_RESET_VALUE;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_events;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            irq_enable <= tcrc_pkg::IRQ_RESET_VALUE;
        end else if (write_hit_enable) begin
            irq_enable <= reg_wdata_in[tcrc_pkg::IRQ_WIDTH-1:0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |((irq_status & ~irq_clear | irq_events) & irq_enable);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read

    always_comb begin
        live_status = '0;
        live_status[tcrc_pkg::STAT_PLL_LOCKED_POS] = pll_locked_out;
        live_status[tcrc_pkg::STAT_POWERDOWN_POS] = powerdown;
        live_status[tcrc_pkg::STAT_FREQ_LOCKED_POS +: NCH] = rx_freq_locked_out;
        live_status[tcrc_pkg::STAT_TX_HELD_POS +: NCH] = tx_pcs_reset_out;
        live_status[tcrc_pkg::STAT_RX_HELD_POS +: NCH] = rx_pcs_reset_out;
        live_status[tcrc_pkg::STAT_CDR_HELD_POS +: NCH] = cdr_reset_out;
    end

    // unmapped and write-only addresses read as zero
    always_comb begin
        next_rdata = '0;
        unique case (reg_addr_in)
            tcrc_pkg::SW_TX_RESET_OFFSET: begin
                next_rdata[NCH-1:0] = sw_tx_reset;
            end
            tcrc_pkg::SW_RX_RESET_OFFSET: begin
                next_rdata[NCH-1:0] = sw_rx_reset;
            end
            tcrc_pkg::SW_ANALOG_RESET_OFFSET: begin
                next_rdata[NCH-1:0] = sw_analog_reset;
            end
            tcrc_pkg::SW_POWERDOWN_OFFSET: begin
                next_rdata[0] = sw_powerdown;
            end
            tcrc_pkg::LIVE_STATUS_OFFSET: begin
                next_rdata = live_status;
            end
            tcrc_pkg::IRQ_STATUS_OFFSET: begin
                next_rdata[tcrc_pkg::IRQ_WIDTH-1:0] = irq_status;
            end
            tcrc_pkg::IRQ_ENABLE_OFFSET: begin
                next_rdata[tcrc_pkg::IRQ_WIDTH-1:0] = irq_enable;
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge clock_in) begin
        if (!nrst_in || !reg_read_in) begin
            reg_rdata_out <= '0;
        end else begin
            reg_rdata_out <= next_rdata;
        end
    end

endmodule
`default_nettype wire

// *** tb/tcrc_chk.sv ***
// assertions on the ports of the transceiver channel reset control block
`timescale 1ns/1ps
`default_nettype none
module tcrc_chk (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire tcrc_pkg::tcrc_chan_reset_type [3:0] chan_reset_in,
    input wire logic block_powerdown_in,
    input wire logic pll_lock_detect_in,
    input wire logic [3:0] cdr_lock_to_data_in,
    input wire logic reg_write_in,
    input wire logic [3:0] tx_pcs_reset_out,
    input wire logic [3:0] rx_pcs_reset_out,
    input wire logic [3:0] cdr_reset_out,
    input wire logic [3:0] pcs_powerdown_out,
    input wire logic [3:0] pma_powerdown_out,
    input wire logic mpll_powerdown_out,
    input wire logic gpll_powerdown_out,
    input wire logic pll_locked_out,
    input wire logic [3:0] rx_freq_locked_out
);
    logic [3:0] tx_req;
    logic [3:0] rx_req;
    logic [3:0] an_req;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            tx_req[i] = chan_reset_in[i].tx_digital;
            rx_req[i] = chan_reset_in[i].rx_digital;
            an_req[i] = chan_reset_in[i].rx_analog;
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!nrst_in);
    // software bits may add to a pin reset, never hide it
    tx_follow_a: assert property ((tx_pcs_reset_out & tx_req) == tx_req)
        else $error("transmit reset does not follow its pin");
    rx_follow_a: assert property ((rx_pcs_reset_out & rx_req) == rx_req)
        else $error("receive reset does not follow its pin");
    cdr_follow_a: assert property ((cdr_reset_out & an_req) == an_req)
        else $error("recovery reset does not follow its pin");
    powerdown_all_a: assert property (block_powerdown_in |-> &{pcs_powerdown_out,
        pma_powerdown_out, mpll_powerdown_out, gpll_powerdown_out})
        else $error("block power-down missed a target");
    powerdown_same_a: assert property ({pcs_powerdown_out, pma_powerdown_out,
        gpll_powerdown_out} == {9{mpll_powerdown_out}})
        else $error("power-down targets disagree");
    pll_status_a: assert property (pll_locked_out == (pll_lock_detect_in
        && !mpll_powerdown_out))
        else $error("pll lock status wrong");
    freq_status_a: assert property (rx_freq_locked_out == (cdr_lock_to_data_in
        & ~cdr_reset_out & ~pcs_powerdown_out))
        else $error("frequency lock status wrong");
    // a reset output may only move when a pin or a register write moved it
    sequence quiet_inputs;
        $past(nrst_in) && $stable(chan_reset_in) && !$past(reg_write_in);
    endsequence
    sequence resets_hold;
        $stable({tx_pcs_reset_out, rx_pcs_reset_out, cdr_reset_out});
    endsequence
    release_quiet_a: assert property (quiet_inputs |-> resets_hold)
        else $error("reset output moved without cause");
endmodule
bind tcrc_top tcrc_chk u_chk (.clock_in, .nrst_in, .chan_reset_in, .block_powerdown_in,
    .pll_lock_detect_in, .cdr_lock_to_data_in, .reg_write_in, .tx_pcs_reset_out,
    .rx_pcs_reset_out, .cdr_reset_out, .pcs_powerdown_out, .pma_powerdown_out,
    .mpll_powerdown_out, .gpll_powerdown_out, .pll_locked_out, .rx_freq_locked_out);
`default_nettype wire

// *** tb/tcrc_fabric_model.sv ***
// fabric-side reset controller model that drives the channel reset pins
`timescale 1ns/1ps
`default_nettype none
module tcrc_fabric_model (
    input wire logic clock_in,
    input wire logic pll_locked_in,
    output var tcrc_pkg::tcrc_chan_reset_type [3:0] chan_reset_out
);
    // all held from power-on until power_up
    initial chan_reset_out = '1;
    task automatic power_up();
        int n;
        repeat (tcrc_pkg::MIN_PULSE_CYCLES) @(posedge clock_in);
        for (n = 0; n < 4; n++)
            chan_reset_out[n].rx_analog <= 1'b0;
        n = 0;
        // bounded, so a missing lock cannot hang the run
        while (!pll_locked_in && n < 1000) begin
            @(posedge clock_in);
            n++;
        end
        @(posedge clock_in);
        for (n = 0; n < 4; n++)
            chan_reset_out[n] <= 3'b000;
    endtask
    task automatic set_levels(input logic [11:0] levels);
        @(posedge clock_in);
        chan_reset_out <= levels;
        repeat (2) @(posedge clock_in);
    endtask
    // len below two only where a scenario asks for a short pulse
    task automatic pulse(input int ch, input int kind, input int len);
        @(posedge clock_in);
        chan_reset_out[ch][kind] <= 1'b1;
        repeat (len) @(posedge clock_in);
        chan_reset_out[ch][kind] <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the transceiver channel reset control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic [11:0] levels;
        logic pd;
        logic lock;
        logic [3:0] cdrl;
        logic [11:0] trc;
        logic [3:0] pwd;
        logic [3:0] freq;
        logic pll;
    } tcrc_row_type;
    // levels: channel n owns bits 3n+2 transmit, 3n+1 receive, 3n analog
    tcrc_row_type rows [7] = '{
        '{12'h000, 1'b0, 1'b1, 4'hf, 12'h000, 4'h0, 4'hf, 1'b1},
        '{12'h004, 1'b0, 1'b1, 4'hf, 12'h100, 4'h0, 4'hf, 1'b1},
        '{12'h010, 1'b0, 1'b1, 4'hf, 12'h020, 4'h0, 4'hf, 1'b1},
        '{12'h040, 1'b0, 1'b1, 4'hf, 12'h004, 4'h0, 4'hb, 1'b1},
        '{12'he00, 1'b0, 1'b1, 4'hf, 12'h888, 4'h0, 4'h7, 1'b1},
        '{12'h000, 1'b1, 1'b1, 4'hf, 12'h000, 4'hf, 4'h0, 1'b0},
        '{12'h000, 1'b0, 1'b0, 4'h5, 12'h000, 4'h0, 4'h5, 1'b0}};
    logic [7:0] offs [3] = '{tcrc_pkg::SW_TX_RESET_OFFSET, tcrc_pkg::SW_RX_RESET_OFFSET,
        tcrc_pkg::SW_ANALOG_RESET_OFFSET};
    logic clock_in = 1'b0;
    logic nrst_in = 1'b0;
    tcrc_pkg::tcrc_chan_reset_type [3:0] chan_reset_in;
    logic block_powerdown_in = 1'b0;
    logic pll_lock_detect_in = 1'b1;
    logic [3:0] cdr_lock_to_data_in = 4'hf;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h00000000;
    logic reg_write_in = 1'b0;
    logic reg_read_in = 1'b0;
    logic [31:0] reg_rdata_out;
    logic [3:0] tx_pcs_reset_out, rx_pcs_reset_out, cdr_reset_out;
    logic [3:0] pcs_powerdown_out, pma_powerdown_out, rx_freq_locked_out;
    logic mpll_powerdown_out, gpll_powerdown_out, pll_locked_out, irq_out;
    logic [31:0] d;
    int fails = 0, n_tests = 0;
    always #4 clock_in = ~clock_in;
    tcrc_top u_tcrc_top (.clock_in, .nrst_in, .chan_reset_in, .block_powerdown_in,
        .pll_lock_detect_in, .cdr_lock_to_data_in, .reg_addr_in, .reg_wdata_in,
        .reg_write_in, .reg_read_in, .reg_rdata_out, .tx_pcs_reset_out, .rx_pcs_reset_out,
        .cdr_reset_out, .pcs_powerdown_out, .pma_powerdown_out, .mpll_powerdown_out,
        .gpll_powerdown_out, .pll_locked_out, .rx_freq_locked_out, .irq_out);
    tcrc_fabric_model u_tcrc_fabric_model (.clock_in, .pll_locked_in(pll_locked_out),
        .chan_reset_out(chan_reset_in));
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] pin_word(input logic [11:0] trc, input logic [3:0] pwd,
        input logic [3:0] freq, input logic pll);
        return {4'h0, trc, pwd, pwd, freq, pwd[0], pwd[0], pll, 1'b0};
    endfunction
    function automatic logic [31:0] pins_now();
        return {4'h0, tx_pcs_reset_out, rx_pcs_reset_out, cdr_reset_out, pcs_powerdown_out,
            pma_powerdown_out, rx_freq_locked_out, mpll_powerdown_out, gpll_powerdown_out,
            pll_locked_out, 1'b0};
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_write_in <= 1'b1;
        @(posedge clock_in);
        reg_write_in <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge clock_in);
        reg_read_in <= 1'b0;
        #1 v = reg_rdata_out;
    endtask
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        #(8 * 20000);
        fails++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge clock_in);
        nrst_in <= 1'b1;
        u_tcrc_fabric_model.power_up();
        foreach (rows[i]) begin
            @(posedge clock_in);
            block_powerdown_in <= rows[i].pd;
            pll_lock_detect_in <= rows[i].lock;
            cdr_lock_to_data_in <= rows[i].cdrl;
            u_tcrc_fabric_model.set_levels(rows[i].levels);
            #1 check("pins", pin_word(rows[i].trc, rows[i].pwd, rows[i].freq, rows[i].pll),
                pins_now());
        end
        @(posedge clock_in);
        block_powerdown_in <= 1'b0;
        pll_lock_detect_in <= 1'b1;
        cdr_lock_to_data_in <= 4'hf;
        $display("test pin table finished");
        for (int k = 0; k < 3; k++) begin
            reg_wr(offs[k], 32'hfffffff5);
            #1 check("soft pins", pin_word(12'h500 >> (4 * k), 4'h0, (k == 2) ? 4'ha : 4'hf,
                1'b1), pins_now());
            reg_rd(offs[k], d);
            check("soft readback", 32'h00000005, d);
            reg_wr(offs[k], 32'h00000000);
            #1 check("soft released", pin_word(12'h000, 4'h0, 4'hf, 1'b1), pins_now());
        end
        reg_wr(tcrc_pkg::SW_POWERDOWN_OFFSET, 32'h00000001);
        #1 check("soft powerdown", pin_word(12'h000, 4'hf, 4'h0, 1'b0), pins_now());
        reg_wr(tcrc_pkg::SW_POWERDOWN_OFFSET, 32'h00000000);
        reg_wr(8'h20, 32'hffffffff);
        reg_rd(8'h20, d);
        check("unmapped read", 32'h00000000, d);
        reg_rd(tcrc_pkg::IRQ_CLEAR_OFFSET, d);
        check("clear register read", 32'h00000000, d);
        reg_wr(tcrc_pkg::LIVE_STATUS_OFFSET, 32'hffffffff);
        reg_rd(tcrc_pkg::LIVE_STATUS_OFFSET, d);
        check("live status", 32'h000000f1, d);
        $display("test registers finished");
        reg_wr(tcrc_pkg::IRQ_CLEAR_OFFSET, 32'h0001ffff);
        reg_wr(tcrc_pkg::IRQ_ENABLE_OFFSET, 32'h0001ffff);
        u_tcrc_fabric_model.pulse(1, 2, 2);
        repeat (4) @(posedge clock_in);
        #1 check("irq after full pulse", 32'h0, {31'h0, irq_out});
        u_tcrc_fabric_model.pulse(1, 2, 1);
        u_tcrc_fabric_model.pulse(2, 0, 1);
        @(posedge clock_in);
        pll_lock_detect_in <= 1'b0;
        cdr_lock_to_data_in <= 4'h7;
        repeat (5) @(posedge clock_in);
        #1 check("irq raised", 32'h1, {31'h0, irq_out});
        reg_rd(tcrc_pkg::IRQ_STATUS_OFFSET, d);
        check("irq status", 32'h0001c402, d);
        reg_wr(tcrc_pkg::IRQ_ENABLE_OFFSET, 32'h00000000);
        repeat (2) @(posedge clock_in);
        #1 check("irq masked", 32'h0, {31'h0, irq_out});
        reg_wr(tcrc_pkg::IRQ_ENABLE_OFFSET, 32'h0001ffff);
        pll_lock_detect_in <= 1'b1;
        cdr_lock_to_data_in <= 4'hf;
        reg_wr(tcrc_pkg::IRQ_CLEAR_OFFSET, 32'h0001c402);
        repeat (2) @(posedge clock_in);
        #1 check("irq cleared", 32'h0, {31'h0, irq_out});
        reg_rd(tcrc_pkg::IRQ_STATUS_OFFSET, d);
        check("irq status cleared", 32'h00000000, d);
        $display("test interrupts finished");
        reg_wr(tcrc_pkg::SW_TX_RESET_OFFSET, 32'h0000000f);
        @(posedge clock_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        nrst_in <= 1'b1;
        #1 check("pins after reset", pin_word(12'h000, 4'h0, 4'hf, 1'b1), pins_now());
        reg_rd(tcrc_pkg::SW_TX_RESET_OFFSET, d);
        check("soft reset cleared", 32'h00000000, d);
        $display("test second reset finished");
        stop_test();
    end
endmodule
`default_nettype wire
